// [hw/framer_irq_pkg.sv]
package framer_irq_pkg;

  // register data width and the part of it that carries flags
  localparam int REG_WIDTH = 8;
  localparam int NUM_EVENTS = 6;

  // flag and enable bit positions, shared by both registers
  localparam int BIT_FRAMING = 0;
  localparam int BIT_CRC = 1;
  localparam int BIT_MIMIC = 2;
  localparam int BIT_FRAME_LOSS = 3;
  localparam int BIT_ALIGNMENT = 4;
  localparam int BIT_ROBBED = 5;

  // register indices below the channel digit; byte address is index * 4
  localparam logic [11:0] IDX_FLAGS = 12'hB04;
  localparam logic [11:0] IDX_MASK = 12'hB05;
  localparam logic [11:0] IDX_CTRL = 12'hB06;
  localparam logic [11:0] IDX_STATE = 12'hB07;

  // control and state register fields
  localparam int CTRL_ROBBED_ENABLE = 0;
  localparam int STATE_FRAME_LOSS = 0;
  localparam int STATE_IRQ = 1;

  // values after reset
  localparam logic [5:0] MASK_RESET = 6'h00;
  localparam logic [5:0] FLAGS_RESET = 6'h00;
  localparam logic CTRL_ROBBED_RESET = 1'b0;

  // signaling layout: 24 channels of A, B, C and D bits
  localparam int SIG_CHANNELS = 24;
  localparam int SIG_BITS = 4;
  localparam int SIG_WIDTH = SIG_CHANNELS * SIG_BITS;

  // register selected by the current address
  typedef enum logic [2:0] {
    SEL_NONE,
    SEL_FLAGS,
    SEL_MASK,
    SEL_CTRL,
    SEL_STATE
  } reg_sel_t;

endpackage : framer_irq_pkg

// [hw/robbed_bit_change_detect.sv]
`timescale 1ns/1ps
module robbed_bit_change_detect (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sig_update,
  input wire logic [framer_irq_pkg::SIG_WIDTH-1:0] sig_bits,
  output logic sig_change
);

  logic primed;
  logic [framer_irq_pkg::SIG_CHANNELS-1:0] differs;

  // one stored nibble per signaling channel, compared on each update
  for (genvar c = 0; c < framer_irq_pkg::SIG_CHANNELS; c++) begin : g_chan
    logic [framer_irq_pkg::SIG_BITS-1:0] held;
    assign differs[c] = sig_update &&
        (sig_bits[c*framer_irq_pkg::SIG_BITS +: framer_irq_pkg::SIG_BITS]
         != held);
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        held <= 4'h0;
      end else if (sig_update) begin
        held <= sig_bits[c*framer_irq_pkg::SIG_BITS +:
                         framer_irq_pkg::SIG_BITS];
      end
    end
  end

  // the first update after reset only loads the history
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      primed <= 1'b0;
    end else if (sig_update) begin
      primed <= 1'b1;
    end
  end

  // one-cycle pulse when any bit of any channel moved
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sig_change <= 1'b0;
    end else begin
      sig_change <= primed && (|differs);
    end
  end

endmodule : robbed_bit_change_detect

// [hw/frame_loss_edge.sv]
`timescale 1ns/1ps
module frame_loss_edge (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic frame_loss,
  output logic frame_loss_held,
  output logic frame_loss_change
);

  // last seen loss-of-frame level; reset means framed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_loss_held <= 1'b0;
    end else begin
      frame_loss_held <= frame_loss;
    end
  end

  // pulse on declaration and on clearance alike
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_loss_change <= 1'b0;
    end else begin
      frame_loss_change <= frame_loss ^ frame_loss_held;
    end
  end

endmodule : frame_loss_edge

// [hw/t1_framer_interrupt_flags.sv]
// Register access over APB and the address map are this design's own decisions.
`timescale 1ns/1ps
module t1_framer_interrupt_flags #(
  parameter logic [3:0] CHANNEL = 4'h0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic mimic_detect,
  input wire logic crc6_error,
  input wire logic framing_bit_error,
  input wire logic alignment_shift,
  input wire logic frame_loss,
  input wire logic sig_update,
  input wire logic [framer_irq_pkg::SIG_WIDTH-1:0] sig_bits,
  output logic robbed_bit_mode,
  output logic framer_irq
);

  // byte addresses: channel digit leads the index, index times four
  localparam logic [31:0] ADDR_FLAGS =
      {14'h0000, CHANNEL, framer_irq_pkg::IDX_FLAGS, 2'b00};
  localparam logic [31:0] ADDR_MASK =
      {14'h0000, CHANNEL, framer_irq_pkg::IDX_MASK, 2'b00};
  localparam logic [31:0] ADDR_CTRL =
      {14'h0000, CHANNEL, framer_irq_pkg::IDX_CTRL, 2'b00};
  localparam logic [31:0] ADDR_STATE =
      {14'h0000, CHANNEL, framer_irq_pkg::IDX_STATE, 2'b00};

  // register contents
  logic [framer_irq_pkg::NUM_EVENTS-1:0] framer_event_flags;
  logic [framer_irq_pkg::NUM_EVENTS-1:0] framer_event_mask;
  logic [framer_irq_pkg::NUM_EVENTS-1:0] read_snapshot;

  // bus decode
  framer_irq_pkg::reg_sel_t sel;
  logic setup_phase;
  logic access_phase;
  logic rd_access;
  logic wr_access;
  logic low_lane;
  logic [7:0] read_byte;

  // event sources and flag update terms
  logic frame_loss_held;
  logic frame_loss_change;
  logic sig_change;
  logic [framer_irq_pkg::NUM_EVENTS-1:0] events;
  logic [framer_irq_pkg::NUM_EVENTS-1:0] read_clear;
  logic [framer_irq_pkg::NUM_EVENTS-1:0] write_clear;
  logic [framer_irq_pkg::NUM_EVENTS-1:0] next_flags;
  logic next_irq;

  // loss-of-frame level turned into a change pulse
  frame_loss_edge u_frame_loss_edge (
    .pclk(pclk),
    .presetn(presetn),
    .frame_loss(frame_loss),
    .frame_loss_held(frame_loss_held),
    .frame_loss_change(frame_loss_change)
  );

  // per-channel signaling history and change detection
  robbed_bit_change_detect u_robbed_bit_change_detect (
    .pclk(pclk),
    .presetn(presetn),
    .sig_update(sig_update),
    .sig_bits(sig_bits),
    .sig_change(sig_change)
  );

  // address decode; anything off the four words is unmapped
  always_comb begin
    case (paddr)
      ADDR_FLAGS: sel = framer_irq_pkg::SEL_FLAGS;
      ADDR_MASK: sel = framer_irq_pkg::SEL_MASK;
      ADDR_CTRL: sel = framer_irq_pkg::SEL_CTRL;
      ADDR_STATE: sel = framer_irq_pkg::SEL_STATE;
      default: sel = framer_irq_pkg::SEL_NONE;
    endcase
  end

  // apb phases; the slave never inserts wait states
  assign setup_phase = psel && !penable;
  assign access_phase = psel && penable;
  assign pready = 1'b1;
  assign pslverr = access_phase && (sel == framer_irq_pkg::SEL_NONE);
  assign rd_access = access_phase && !pwrite;
  assign wr_access = access_phase && pwrite && pstrb[0];
  assign low_lane = pstrb[0];

  // read mux; unused and reserved bits read as zero
  always_comb begin
    read_byte = 8'h00;
    case (sel)
      framer_irq_pkg::SEL_FLAGS: begin
        read_byte[5:0] = framer_event_flags;
      end
      framer_irq_pkg::SEL_MASK: begin
        read_byte[5:0] = framer_event_mask;
      end
      framer_irq_pkg::SEL_CTRL: begin
        read_byte[framer_irq_pkg::CTRL_ROBBED_ENABLE] = robbed_bit_mode;
      end
      framer_irq_pkg::SEL_STATE: begin
        read_byte[framer_irq_pkg::STATE_FRAME_LOSS] = frame_loss_held;
        read_byte[framer_irq_pkg::STATE_IRQ] = framer_irq;
      end
      default: begin
        read_byte = 8'h00;
      end
    endcase
  end

  // read data is captured in the setup cycle and held through access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (setup_phase && !pwrite) begin
      prdata <= {24'h000000, read_byte};
    end
  end

  // remember exactly which flags the reader was shown
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      read_snapshot <= framer_irq_pkg::FLAGS_RESET;
    end else if (setup_phase) begin
      if (!pwrite && sel == framer_irq_pkg::SEL_FLAGS) begin
        read_snapshot <= framer_event_flags;
      end else begin
        read_snapshot <= framer_irq_pkg::FLAGS_RESET;
      end
    end
  end

  // enable register, six writable bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      framer_event_mask <= framer_irq_pkg::MASK_RESET;
    end else if (wr_access && sel == framer_irq_pkg::SEL_MASK) begin
      framer_event_mask <= pwdata[5:0];
    end
  end

  // control register: robbed-bit signaling on or off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      robbed_bit_mode <= framer_irq_pkg::CTRL_ROBBED_RESET;
    end else if (wr_access && sel == framer_irq_pkg::SEL_CTRL) begin
      robbed_bit_mode <= pwdata[framer_irq_pkg::CTRL_ROBBED_ENABLE];
    end
  end

  // event vector in flag-bit order
  always_comb begin
    events = '0;
    events[framer_irq_pkg::BIT_MIMIC] = mimic_detect;
    events[framer_irq_pkg::BIT_CRC] = crc6_error;
    // no dependence on frame_loss here
    events[framer_irq_pkg::BIT_FRAMING] = framing_bit_error;
    events[framer_irq_pkg::BIT_FRAME_LOSS] = frame_loss_change;
    events[framer_irq_pkg::BIT_ALIGNMENT] = alignment_shift;
    // signaling changes count only with robbed-bit signaling on
    events[framer_irq_pkg::BIT_ROBBED] =
        sig_change && robbed_bit_mode;
  end

  // clears: completed read of shown bits, or write of ones
  assign read_clear = (rd_access && sel == framer_irq_pkg::SEL_FLAGS)
      ? read_snapshot : '0;
  assign write_clear = (wr_access && sel == framer_irq_pkg::SEL_FLAGS)
      ? pwdata[5:0] : '0;

  // per-flag update; an event in the clearing cycle wins over the clear
  for (genvar i = 0; i < framer_irq_pkg::NUM_EVENTS; i++) begin : g_flag
    assign next_flags[i] = (framer_event_flags[i] &&
        !(read_clear[i] || write_clear[i])) || events[i];
  end

  // sticky status flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      framer_event_flags <= framer_irq_pkg::FLAGS_RESET;
    end else begin
      framer_event_flags <= next_flags;
    end
  end

  // request is the OR of enabled flags; signaling gated by mode too
  always_comb begin
    next_irq = |(framer_event_flags & framer_event_mask);
    // bit 5 contributes only while robbed-bit signaling is on
    if (!robbed_bit_mode) begin
      next_irq = |(framer_event_flags & framer_event_mask &
          6'h1F);
    end
  end

  // registered interrupt request, one cycle behind the flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      framer_irq <= 1'b0;
    end else begin
      framer_irq <= next_irq;
    end
  end

  // low byte lane is the only one holding register bits
  logic unused_lanes;
  assign unused_lanes = low_lane;

endmodule : t1_framer_interrupt_flags

// [sim/t1_framer_interrupt_flags_monitor.sv]
`timescale 1ns/1ps
module t1_framer_interrupt_flags_monitor #(
  parameter logic [3:0] CHANNEL = 4'h0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic mimic_detect,
  input wire logic crc6_error,
  input wire logic framing_bit_error,
  input wire logic alignment_shift,
  input wire logic frame_loss,
  input wire logic sig_update,
  input wire logic robbed_bit_mode,
  input wire logic framer_irq
);
  logic [5:0] mask;
  logic fl_d;
  logic acc;
  logic wr;
  logic hit;
  logic ev;
  // access decode and any-event summary
  assign acc = psel && penable;
  assign wr = acc && pwrite && pstrb[0];
  assign hit = paddr[31:18] == 14'h0 && paddr[17:14] == CHANNEL &&
    paddr[13:4] == 10'h2C1;
  assign ev = mimic_detect || crc6_error || framing_bit_error ||
    alignment_shift || sig_update || frame_loss != fl_d;
  // shadow of the enable register and the loss-of-frame history
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask <= 6'h00;
      fl_d <= 1'b0;
    end else begin
      fl_d <= frame_loss;
      if (wr && hit && paddr[3:0] == 4'h4) begin
        mask <= pwdata[5:0];
      end
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_HI_ZERO: assert property (prdata[31:8] == 24'h0)
    else $error("upper read data not zero");
  AST_UNMAPPED: assert property (acc && !hit |-> pslverr)
    else $error("unmapped access not refused");
  AST_ERR_ACC: assert property (pslverr |-> acc)
    else $error("error outside access phase");
  AST_MODE: assert property ($changed(robbed_bit_mode) |->
    $past(wr && hit && paddr[3:0] == 4'h8))
    else $error("robbed-bit mode changed without a write");
  AST_RISE: assert property ($rose(framer_irq) |-> $past(ev) ||
    $past(ev, 2) || $past(ev, 3) || $past(ev, 4) || $past(wr) ||
    $past(wr, 2))
    else $error("interrupt rose without a cause");
  AST_FALL: assert property ($fell(framer_irq) |-> $past(acc) ||
    $past(acc, 2) || $past(acc, 3))
    else $error("interrupt fell without an access");
  AST_MASKED: assert property ($rose(framer_irq) |->
    $past(mask) != 6'h00)
    else $error("interrupt rose with all enables off");
  AST_CRC: assert property (crc6_error && mask[1] && !psel |->
    ##2 framer_irq)
    else $error("crc error gave no interrupt");
  AST_FRAMING: assert property (framing_bit_error && mask[0] &&
    !psel |-> ##2 framer_irq)
    else $error("framing error gave no interrupt");
endmodule : t1_framer_interrupt_flags_monitor

bind t1_framer_interrupt_flags t1_framer_interrupt_flags_monitor #(
  .CHANNEL(CHANNEL)
) mon (
  .pclk(pclk),
  .presetn(presetn),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .pwdata(pwdata),
  .pstrb(pstrb),
  .prdata(prdata),
  .pslverr(pslverr),
  .mimic_detect(mimic_detect),
  .crc6_error(crc6_error),
  .framing_bit_error(framing_bit_error),
  .alignment_shift(alignment_shift),
  .frame_loss(frame_loss),
  .sig_update(sig_update),
  .robbed_bit_mode(robbed_bit_mode),
  .framer_irq(framer_irq)
);

// [sim/t1_framer_interrupt_flags_bench.sv]
`timescale 1ns/1ps
module t1_framer_interrupt_flags_bench;
  localparam logic [3:0] CH = 4'h1;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [4:0] ev = 5'h00;
  logic frame_loss = 1'b0;
  logic sig_update = 1'b0;
  logic [framer_irq_pkg::SIG_WIDTH-1:0] sig_bits = 96'h0;
  logic robbed_bit_mode;
  logic framer_irq;
  logic [31:0] rd_data;
  logic rd_err;
  int fails = 0;
  int num_checks = 0;
  int b;
  // free-running bus clock
  initial forever #5 pclk = ~pclk;
  t1_framer_interrupt_flags #(.CHANNEL(CH)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mimic_detect(ev[2]), .crc6_error(ev[1]), .framing_bit_error(ev[0]),
    .alignment_shift(ev[4]), .frame_loss(frame_loss),
    .sig_update(sig_update), .sig_bits(sig_bits),
    .robbed_bit_mode(robbed_bit_mode), .framer_irq(framer_irq)
  );
  function automatic logic [31:0] ra(input logic [11:0] idx);
    return {14'h0, CH, idx, 2'h0};
  endfunction : ra
  // one apb transfer, setup then access until pready
  task automatic xfer(input logic w, input logic [31:0] a,
    input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= 4'hF;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd_data = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic rdchk(input logic [11:0] idx, input logic [31:0] exp);
    xfer(1'b0, ra(idx), 32'h0);
    chk(rd_data, exp);
    chk({31'h0, rd_err}, 32'h0);
  endtask : rdchk
  // one framer event; index 3 toggles the loss-of-frame level
  task automatic pulse(input int k);
    @(posedge pclk);
    if (k == 3) frame_loss <= ~frame_loss;
    else ev[k] <= 1'b1;
    @(posedge pclk);
    ev <= 5'h00;
    repeat (4) @(posedge pclk);
  endtask : pulse
  task automatic sigp(input logic [95:0] v);
    @(posedge pclk);
    sig_bits <= v;
    sig_update <= 1'b1;
    @(posedge pclk);
    sig_update <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask : sigp
  task automatic summarize();
    if (fails == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : summarize
  // watchdog against a hung transfer
  initial begin
    #100000;
    fails++;
    summarize();
  end
  // main sequence
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(framer_irq_pkg::IDX_FLAGS, 32'h0);
    rdchk(framer_irq_pkg::IDX_MASK, 32'h0);
    xfer(1'b0, ra(12'hB08), 32'h0);
    chk({31'h0, rd_err}, 32'h1);
    chk(rd_data, 32'h0);
    pulse(0);
    chk({31'h0, framer_irq}, 32'h0);
    rdchk(framer_irq_pkg::IDX_STATE, 32'h0);
    rdchk(framer_irq_pkg::IDX_FLAGS, 32'h1);
    xfer(1'b1, ra(framer_irq_pkg::IDX_MASK), 32'h3F);
    rdchk(framer_irq_pkg::IDX_MASK, 32'h3F);
    for (int i = 0; i < 6; i++) begin
      b = (i == 5) ? 3 : i;
      pulse(b);
      chk({31'h0, framer_irq}, 32'h1);
      rdchk(framer_irq_pkg::IDX_STATE, {30'h0, 1'b1, frame_loss});
      rdchk(framer_irq_pkg::IDX_FLAGS, 32'h1 << b);
      repeat (2) @(posedge pclk);
      chk({31'h0, framer_irq}, 32'h0);
      rdchk(framer_irq_pkg::IDX_FLAGS, 32'h0);
    end
    // writing a one also clears a flag
    pulse(1);
    xfer(1'b1, ra(framer_irq_pkg::IDX_FLAGS), 32'h2);
    rdchk(framer_irq_pkg::IDX_FLAGS, 32'h0);
    repeat (2) @(posedge pclk);
    chk({31'h0, framer_irq}, 32'h0);
    sigp(96'h0);
    sigp(96'h1);
    rdchk(framer_irq_pkg::IDX_FLAGS, 32'h0);
    xfer(1'b1, ra(framer_irq_pkg::IDX_CTRL), 32'h1);
    rdchk(framer_irq_pkg::IDX_CTRL, 32'h1);
    chk({31'h0, robbed_bit_mode}, 32'h1);
    sigp(96'h10);
    chk({31'h0, framer_irq}, 32'h1);
    rdchk(framer_irq_pkg::IDX_FLAGS, 32'h20);
    summarize();
  end
endmodule : t1_framer_interrupt_flags_bench
